// ---- src/scm_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the capacitor monitor
// Assumes: 32-bit AXI4-Lite word per register, 16-bit register contents in the low bits
// Notes: Level registers sit at SCM_LVL_BASE + 4 * alarm index
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH

`define SCM_CLK_HZ 40000000
`define SCM_A_CTL 8'h00
`define SCM_A_PERIOD 8'h04
`define SCM_A_MON 8'h08
`define SCM_A_MON_MSK 8'h0c
`define SCM_A_ALARM 8'h10
`define SCM_A_ALM_MSK 8'h14
`define SCM_A_ALM_CLR 8'h18
`define SCM_A_CAP 8'h1c
`define SCM_A_ESR 8'h20
`define SCM_A_COUNT 8'h24
`define SCM_LVL_BASE 8'h40
`define SCM_LVL_LAST 8'h74
`define SCM_CTL_START 0
`define SCM_CTL_SCALE 1
`define SCM_CTL_AUXBUF 2
`define SCM_MON_CAP_FAIL 0
`define SCM_MON_ESR_FAIL 1
`define SCM_MON_CAP_DONE 2
`define SCM_MON_ESR_DONE 3
`define SCM_MON_ACTIVE 4
`define SCM_RST_CTL 16'h0000
`define SCM_RST_MASK 16'h0000
`define SCM_NUM_ALARMS 14
`define SCM_OVER_DIR 14'h26aa
`define SCM_REPEAT_STEP_S 10
`define SCM_CAP_TICK_NS 1000
`define SCM_SCALE_RATIO 100
`define SCM_ESR_HALF_US 100
`define SCM_ESR_TOGGLES 8
`define SCM_ESR_LSB_DIV 64
`define SCM_ESR_FAIL_MULT 1024
`define SCM_STEP_MV 200

`endif

// ---- src/scm_pkg.sv ----
// Purpose: Types shared by the capacitor monitor
// Assumes: Nothing beyond the map header
// Notes: State of the monitor sequencer
package scm_pkg;
  typedef enum logic [1:0] {
    SCM_IDLE,
    SCM_CAP_DISCH,
    SCM_ESR_PULSE,
    SCM_ESR_WAIT
  } scm_state_e;
endpackage

// ---- src/scm_monitor.sv ----
// Purpose: Capacitance/ESR test sequencer, limit alarms and alert logic with AXI4-Lite registers
// Assumes: ADC results arrive on the same clock; analog pins pass a three-stage synchroniser
// Notes: SMBus engine sits outside; it pulses ara_ack once it has answered the alert address
// Contract
// - Test discharges the stack by only a small fixed step while online.
// - Power failure during a test aborts it; the device enters backup.
// - Capacitance test waits for charge done, disables charger, times fixed discharge.
// - Scale bit 0 selects coarse capacitance scale, 1 a hundredfold finer one.
// - ESR test follows at once, toggling the controller and measuring changes.
// - ESR result counts sense resistance divided by sixty-four.
// - Host sets start bit; device clears it when the measurement begins.
// - Non-zero repeat period reruns the measurement, ten seconds per count.
// - Failed capacitance or ESR test sets its failed monitor flag.
// - Capacitance fails on power loss or charge-good trip; ESR then fails too.
// - ESR above 1024 times sense resistance reports a failure.
// - ESR test current adapts to the previously measured ESR.
// - Monitor sets and clears flags; masked rising edges pull the alert low.
// - All limit checks are disabled after reset.
// - Enabled limit excursion sets its alarm and pulls the alert low.
// - Limits are checked only at each ADC conversion of a channel.
// - Alert released after alert-address answer, reasserted only on a new event.
// - Alarms latch until cleared by clear-register one or mask zero.
// - Voltages have under and over levels; cells share one pair; currents one each.
// - Die temperature has hot and cold levels, enabled in the alarm mask.
// - Control bit enables aux input buffer; aux has own levels and enables.
// - Two strap pins give capacitor count minus one in a read-only register.
// - Registers are sixteen bits wide, one per command code.
// - Only the device that answered the alert address releases its alert.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`include "scm_map.svh"
`timescale 1ns/1ps
`default_nettype none

module scm_monitor #(
  parameter int unsigned REPEAT_STEP_CYC = `SCM_REPEAT_STEP_S * `SCM_CLK_HZ,
  parameter int unsigned CAP_TICK_CYC = (`SCM_CAP_TICK_NS * (`SCM_CLK_HZ / 1000000) + 999) / 1000,
  parameter int unsigned ESR_HALF_CYC = `SCM_ESR_HALF_US * (`SCM_CLK_HZ / 1000000)
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic power_fail,
  input wire logic charge_good_output,
  input wire logic charge_complete,
  input wire logic step_reached,
  input wire logic cell_count_sel_lo,
  input wire logic cell_count_sel_hi,
  input wire logic adc_valid,
  input wire logic [3:0] adc_channel,
  input wire logic [15:0] adc_data,
  input wire logic esr_valid,
  input wire logic [16:0] esr_value,
  input wire logic ara_ack,
  output logic backup_mode,
  output logic charger_disable,
  output logic discharge_en,
  output logic esr_switch,
  output logic [1:0] esr_current_sel,
  output logic aux_buffer_en,
  output logic alert_o,
  output logic alert_oe
);
  import scm_pkg::*;

  localparam int NA = `SCM_NUM_ALARMS;
  localparam logic [NA-1:0] OVER_DIR = `SCM_OVER_DIR;
  localparam logic [16:0] ESR_LIMIT = 17'(`SCM_ESR_FAIL_MULT * `SCM_ESR_LSB_DIV);
  localparam logic [31:0] TICK_FINE = 32'(CAP_TICK_CYC);
  localparam logic [31:0] TICK_COARSE = 32'(CAP_TICK_CYC * `SCM_SCALE_RATIO);

  if (REPEAT_STEP_CYC < 1 || CAP_TICK_CYC < 1 || ESR_HALF_CYC < 1) begin : g_bad_param
    $error("scm_monitor: timing parameters must be at least one cycle");
  end

  // Input sync order: power_fail, charge good, charge complete, step, strap lo, strap hi
  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] sync3;
    logic [5:0] pin;
    scm_state_e state;
    logic [15:0] ctl;
    logic [15:0] period;
    logic [4:0] mon;
    logic [4:0] mon_msk;
    logic [NA-1:0] alarm;
    logic [NA-1:0] alm_msk;
    logic [NA-1:0][15:0] lvl;
    logic [15:0] meas_cap;
    logic [15:0] meas_esr;
    logic [31:0] tick_cnt;
    logic [16:0] cap_cnt;
    logic [4:0] toggles;
    logic sw;
    logic [31:0] step_cnt;
    logic [15:0] rep_cnt;
    logic rep_due;
    logic alert;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scm_regs_s;

  scm_regs_s r;
  scm_regs_s next_r;

  logic pf;
  logic cgood;
  logic chg_done;
  logic step_hit;

  assign pf = r.pin[0];
  assign cgood = r.pin[1];
  assign chg_done = r.pin[2];
  assign step_hit = r.pin[3];

  function automatic logic chan_match(input int i, input logic [3:0] ch);
    logic hit;
    hit = 1'b0;
    if (i < 2) begin
      hit = (ch < 4'h4);
    end else if (i < 10) begin
      hit = (ch == 4'(i / 2 + 3));
    end else if (i == 10) begin
      hit = (ch == 4'h8);
    end else if (i == 11) begin
      hit = (ch == 4'h9);
    end else begin
      hit = (ch == 4'ha);
    end
    return hit;
  endfunction

  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = d[7:0];
    end
    if (be[1]) begin
      v[15:8] = d[15:8];
    end
    return v;
  endfunction

  assign s_axil_awready = !r.aw_got && !r.bvalid;
  assign s_axil_wready = !r.w_got && !r.bvalid;
  assign s_axil_arready = !r.rvalid;
  assign s_axil_bvalid = r.bvalid;
  assign s_axil_bresp = r.bresp;
  assign s_axil_rvalid = r.rvalid;
  assign s_axil_rdata = r.rdata;
  assign s_axil_rresp = r.rresp;
  assign backup_mode = pf;
  assign charger_disable = (r.state != SCM_IDLE) && (r.state != SCM_ESR_PULSE);
  assign discharge_en = (r.state == SCM_CAP_DISCH);
  assign esr_switch = r.sw;
  assign aux_buffer_en = r.ctl[`SCM_CTL_AUXBUF];
  assign alert_o = 1'b0;
  assign alert_oe = r.alert;

  always_comb begin
    logic [NA-1:0] alm_set;
    logic [NA-1:0] alm_clr;
    logic [4:0] mon_old;
    logic start_req;
    logic wr_do;
    logic [7:0] ra;
    logic [31:0] tick_len;
    int li;
    alm_set = '0;
    alm_clr = '0;
    start_req = 1'b0;
    wr_do = 1'b0;
    ra = s_axil_araddr;
    li = 0;
    next_r = r;
    mon_old = r.mon;
    tick_len = r.ctl[`SCM_CTL_SCALE] ? TICK_FINE : TICK_COARSE;

    // Three-stage synchronisers; a change counts once stages two and three agree
    next_r.sync1 = {cell_count_sel_hi, cell_count_sel_lo, step_reached, charge_complete,
                    charge_good_output, power_fail};
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    for (int b = 0; b < 6; b++) begin
      if (r.sync2[b] == r.sync3[b]) begin
        next_r.pin[b] = r.sync3[b];
      end
    end

    // Register write channel
    if (s_axil_awvalid && s_axil_awready) begin
      next_r.aw_got = 1'b1;
      next_r.waddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axil_wdata;
      next_r.wstrb = s_axil_wstrb;
    end
    if (r.aw_got && r.w_got) begin
      wr_do = 1'b1;
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'b00;
      if (r.waddr == `SCM_A_CTL) begin
        next_r.ctl = lane16(r.ctl, r.wdata, r.wstrb);
      end else if (r.waddr == `SCM_A_PERIOD) begin
        next_r.period = lane16(r.period, r.wdata, r.wstrb);
      end else if (r.waddr == `SCM_A_MON_MSK) begin
        next_r.mon_msk = r.wdata[4:0];
      end else if (r.waddr == `SCM_A_ALM_MSK) begin
        next_r.alm_msk = r.wdata[NA-1:0];
        alm_clr = ~r.wdata[NA-1:0];
      end else if (r.waddr == `SCM_A_ALM_CLR) begin
        alm_clr = r.wdata[NA-1:0];
      end else if (r.waddr >= `SCM_LVL_BASE && r.waddr <= `SCM_LVL_LAST && r.waddr[1:0] == 2'b00) begin
        li = int'((r.waddr - `SCM_LVL_BASE) >> 2);
        next_r.lvl[li] = lane16(r.lvl[li], r.wdata, r.wstrb);
      end else if (r.waddr == `SCM_A_MON || r.waddr == `SCM_A_ALARM || r.waddr == `SCM_A_CAP ||
                   r.waddr == `SCM_A_ESR || r.waddr == `SCM_A_COUNT) begin
        next_r.bresp = 2'b00;
      end else begin
        next_r.bresp = 2'b10;
      end
    end
    if (r.bvalid && s_axil_bready) begin
      next_r.bvalid = 1'b0;
    end

    // Register read channel, 16-bit contents in the low half
    if (r.rvalid && s_axil_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axil_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = 2'b00;
      next_r.rdata = 32'h0000_0000;
      if (ra == `SCM_A_CTL) begin
        next_r.rdata[15:0] = r.ctl;
      end else if (ra == `SCM_A_PERIOD) begin
        next_r.rdata[15:0] = r.period;
      end else if (ra == `SCM_A_MON) begin
        next_r.rdata[4:0] = r.mon;
      end else if (ra == `SCM_A_MON_MSK) begin
        next_r.rdata[4:0] = r.mon_msk;
      end else if (ra == `SCM_A_ALARM) begin
        next_r.rdata[NA-1:0] = r.alarm;
      end else if (ra == `SCM_A_ALM_MSK) begin
        next_r.rdata[NA-1:0] = r.alm_msk;
      end else if (ra == `SCM_A_ALM_CLR) begin
        next_r.rdata = 32'h0000_0000;
      end else if (ra == `SCM_A_CAP) begin
        next_r.rdata[15:0] = r.meas_cap;
      end else if (ra == `SCM_A_ESR) begin
        next_r.rdata[15:0] = r.meas_esr;
      end else if (ra == `SCM_A_COUNT) begin
        next_r.rdata[1:0] = {r.pin[5], r.pin[4]};
      end else if (ra >= `SCM_LVL_BASE && ra <= `SCM_LVL_LAST && ra[1:0] == 2'b00) begin
        next_r.rdata[15:0] = r.lvl[int'((ra - `SCM_LVL_BASE) >> 2)];
      end else begin
        next_r.rresp = 2'b10;
      end
    end

    // Repeat scheduling: one step every REPEAT_STEP_CYC cycles
    if (r.period != 16'h0000 && !r.rep_due) begin
      if (r.step_cnt >= REPEAT_STEP_CYC - 1) begin
        next_r.step_cnt = 32'h0000_0000;
        if (r.rep_cnt + 16'h0001 >= r.period) begin
          next_r.rep_due = 1'b1;
          next_r.rep_cnt = 16'h0000;
        end else begin
          next_r.rep_cnt = r.rep_cnt + 16'h0001;
        end
      end else begin
        next_r.step_cnt = r.step_cnt + 32'h0000_0001;
      end
    end else if (r.period == 16'h0000) begin
      next_r.rep_due = 1'b0;
      next_r.step_cnt = 32'h0000_0000;
      next_r.rep_cnt = 16'h0000;
    end
    start_req = next_r.ctl[`SCM_CTL_START] || r.rep_due;

    // Measurement sequencer
    case (r.state)
      SCM_IDLE: begin
        next_r.sw = 1'b0;
        if (start_req && chg_done && !pf) begin
          next_r.ctl[`SCM_CTL_START] = 1'b0;
          next_r.rep_due = 1'b0;
          next_r.step_cnt = 32'h0000_0000;
          next_r.rep_cnt = 16'h0000;
          next_r.mon = 5'b1_0000;
          next_r.tick_cnt = 32'h0000_0000;
          next_r.cap_cnt = 17'h0_0000;
          next_r.state = SCM_CAP_DISCH;
        end
      end
      SCM_CAP_DISCH: begin
        if (pf || !cgood || r.cap_cnt[16]) begin
          next_r.mon = 5'b0_0011;
          next_r.state = SCM_IDLE;
        end else if (step_hit) begin
          next_r.meas_cap = r.cap_cnt[15:0];
          next_r.mon[`SCM_MON_CAP_DONE] = 1'b1;
          next_r.tick_cnt = 32'h0000_0000;
          next_r.toggles = 5'h00;
          next_r.sw = 1'b1;
          next_r.state = SCM_ESR_PULSE;
        end else if (r.tick_cnt >= tick_len - 32'h0000_0001) begin
          next_r.tick_cnt = 32'h0000_0000;
          next_r.cap_cnt = r.cap_cnt + 17'h0_0001;
        end else begin
          next_r.tick_cnt = r.tick_cnt + 32'h0000_0001;
        end
      end
      SCM_ESR_PULSE: begin
        if (pf) begin
          next_r.sw = 1'b0;
          next_r.mon[`SCM_MON_ESR_FAIL] = 1'b1;
          next_r.mon[`SCM_MON_ACTIVE] = 1'b0;
          next_r.state = SCM_IDLE;
        end else if (r.tick_cnt >= ESR_HALF_CYC - 1) begin
          next_r.tick_cnt = 32'h0000_0000;
          next_r.sw = !r.sw;
          next_r.toggles = r.toggles + 5'h01;
          if (r.toggles == 5'(2 * `SCM_ESR_TOGGLES - 1)) begin
            next_r.sw = 1'b0;
            next_r.state = SCM_ESR_WAIT;
          end
        end else begin
          next_r.tick_cnt = r.tick_cnt + 32'h0000_0001;
        end
      end
      SCM_ESR_WAIT: begin
        if (pf) begin
          next_r.mon[`SCM_MON_ESR_FAIL] = 1'b1;
          next_r.mon[`SCM_MON_ACTIVE] = 1'b0;
          next_r.state = SCM_IDLE;
        end else if (esr_valid) begin
          if (esr_value > ESR_LIMIT) begin
            next_r.mon[`SCM_MON_ESR_FAIL] = 1'b1;
          end else begin
            next_r.meas_esr = esr_value[15:0];
            next_r.mon[`SCM_MON_ESR_DONE] = 1'b1;
          end
          next_r.mon[`SCM_MON_ACTIVE] = 1'b0;
          next_r.state = SCM_IDLE;
        end
      end
      default: begin
        next_r.state = SCM_IDLE;
      end
    endcase

    // Limit checks at each conversion of a channel
    if (adc_valid) begin
      for (int i = 0; i < NA; i++) begin
        if (r.alm_msk[i] && chan_match(i, adc_channel)) begin
          if (OVER_DIR[i] ? ($signed(adc_data) > $signed(r.lvl[i]))
                          : ($signed(adc_data) < $signed(r.lvl[i]))) begin
            alm_set[i] = 1'b1;
          end
        end
      end
    end
    // A new excursion wins over an alarm-clear write in the same cycle, but not over a mask-zero clear
    next_r.alarm = (r.alarm & ~alm_clr) | (alm_set & next_r.alm_msk);

    // Alert: new alarm or masked monitor rising edge; released after alert-address answer
    if ((|(alm_set & next_r.alm_msk & ~r.alarm)) || (|(next_r.mon & ~mon_old & r.mon_msk))) begin
      next_r.alert = 1'b1;
    end else if (ara_ack) begin
      next_r.alert = 1'b0;
    end
  end

  // Lower measured ESR allows a larger test current
  always_comb begin
    esr_current_sel = 2'(3 - int'(r.meas_esr[15:14]));
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r <= '0;
      r.state <= SCM_IDLE;
      r.ctl <= `SCM_RST_CTL;
      r.alm_msk <= NA'(`SCM_RST_MASK);
      r.mon_msk <= 5'h00;
    end else begin
      r <= next_r;
    end
  end
endmodule

`default_nettype wire

// ---- tb/scm_host_model.sv ----
// Purpose: Host side of the alert line, answering the alert address after a delay
// Assumes: Alert line has a pull-up and is low while alert_oe is high
// Notes: Reads the alert address again every 256 cycles while the line stays low
`timescale 1ns/1ps
`default_nettype none
module scm_host_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic answer_en,
  input wire logic [7:0] delay,
  output logic ara_ack
);
  logic line;
  logic [7:0] cnt;
  assign line = alert_oe ? alert_o : 1'b1;
  always_ff @(posedge clk_sys) begin
    if (srst || line || !answer_en) begin
      cnt <= 8'h00;
      ara_ack <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      // Pulse marks the device having answered the alert address read
      ara_ack <= (cnt == delay);
    end
  end
endmodule
`default_nettype wire

// ---- tb/scm_monitor_checker.sv ----
// Purpose: Port assertions for the capacitor monitor
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into every scm_monitor instance
`timescale 1ns/1ps
`default_nettype none
module scm_monitor_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic power_fail,
  input wire logic adc_valid,
  input wire logic esr_valid,
  input wire logic ara_ack,
  input wire logic backup_mode,
  input wire logic charger_disable,
  input wire logic discharge_en,
  input wire logic esr_switch,
  input wire logic alert_o,
  input wire logic alert_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_read_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read not answered");
  a_write_single: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
    else $error("write response repeated");
  a_read_single: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
    else $error("read response repeated");
  a_alert_low: assert property (alert_oe |-> !alert_o)
    else $error("alert not driven low");
  a_ara_release: assert property (ara_ack && alert_oe && !adc_valid && !esr_valid && !charger_disable
    && !discharge_en |=> !alert_oe) else $error("alert kept after answer");
  a_backup_sync: assert property (power_fail [*6] |-> backup_mode)
    else $error("backup not entered");
  a_abort_backup: assert property (backup_mode |-> ##2 !discharge_en)
    else $error("test not aborted");
  a_charger_off: assert property (discharge_en |-> charger_disable)
    else $error("charger on during discharge");
  a_start_online: assert property ($rose(discharge_en) |-> !backup_mode)
    else $error("test started in backup");
  a_esr_phase: assert property (esr_switch |-> !discharge_en)
    else $error("esr switching during discharge");
  c_alert: cover property ($rose(alert_oe));
  c_discharge: cover property ($rose(discharge_en));
  c_esr: cover property ($rose(esr_switch));
endmodule
bind scm_monitor scm_monitor_checker scm_monitor_checker_i (.clk_sys(clk_sys), .srst(srst),
  .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready), .s_axil_rvalid(s_axil_rvalid),
  .s_axil_rready(s_axil_rready), .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
  .power_fail(power_fail), .adc_valid(adc_valid), .esr_valid(esr_valid), .ara_ack(ara_ack),
  .backup_mode(backup_mode), .charger_disable(charger_disable), .discharge_en(discharge_en),
  .esr_switch(esr_switch), .alert_o(alert_o), .alert_oe(alert_oe));
`default_nettype wire

// ---- tb/test_supercap_monitor_alarm_logic.sv ----
// Purpose: Self-checking bench for the capacitor monitor
// Assumes: Shortened tick, ESR half period and repeat step
// Notes: Registers through AXI4-Lite tasks; host model answers alerts
`include "scm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_supercap_monitor_alarm_logic;
  logic clk_sys = 1'b0, srst = 1'b1, s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_arvalid = 1'b0;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00, ara_delay = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, rd;
  logic s_axil_awready, s_axil_wready, s_axil_arready, s_axil_bvalid, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp, rs, esr_current_sel;
  logic power_fail = 1'b0, charge_good_output = 1'b1, charge_complete = 1'b1, step_reached = 1'b0;
  logic cell_count_sel_lo = 1'b0, cell_count_sel_hi = 1'b0, adc_valid = 1'b0, esr_valid = 1'b0;
  logic answer_en = 1'b1, ara_ack, backup_mode, charger_disable, discharge_en, esr_switch;
  logic aux_buffer_en, alert_o, alert_oe, s_axil_bready = 1'b0, s_axil_rready = 1'b0;
  logic [3:0] adc_channel = 4'h0, ch, s_axil_wstrb = 4'hf;
  logic [15:0] adc_data = 16'h0000;
  logic [16:0] esr_value = 17'h00000;
  logic [13:0] od = `SCM_OVER_DIR;
  int mismatches = 0, cmp_count = 0, n, i, c0, c1, cyc = 0, t0;
  scm_monitor #(.REPEAT_STEP_CYC(100), .CAP_TICK_CYC(2), .ESR_HALF_CYC(2)) scm_monitor_i (
    .clk_sys(clk_sys), .srst(srst), .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
    .power_fail(power_fail), .charge_good_output(charge_good_output), .charge_complete(charge_complete),
    .step_reached(step_reached), .cell_count_sel_lo(cell_count_sel_lo), .cell_count_sel_hi(cell_count_sel_hi),
    .adc_valid(adc_valid), .adc_channel(adc_channel), .adc_data(adc_data), .esr_valid(esr_valid),
    .esr_value(esr_value), .ara_ack(ara_ack), .backup_mode(backup_mode), .charger_disable(charger_disable),
    .discharge_en(discharge_en), .esr_switch(esr_switch), .esr_current_sel(esr_current_sel),
    .aux_buffer_en(aux_buffer_en), .alert_o(alert_o), .alert_oe(alert_oe));
  scm_host_model scm_host_model_i (.clk_sys(clk_sys), .srst(srst), .alert_o(alert_o), .alert_oe(alert_oe),
    .answer_en(answer_en), .delay(ara_delay), .ara_ack(ara_ack));
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  task close_out;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    s_axil_awaddr <= a;
    s_axil_wdata <= {16'h0000, d};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b0;
    do begin
      @(posedge clk_sys);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
      if (s_axil_bvalid && !s_axil_bready) s_axil_bready <= 1'b1;
    end while (!(s_axil_bvalid && s_axil_bready));
    rs = s_axil_bresp;
  endtask
  task rd_reg(input logic [7:0] a);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b0;
    do begin
      @(posedge clk_sys);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
      if (s_axil_rvalid && !s_axil_rready) s_axil_rready <= 1'b1;
    end while (!(s_axil_rvalid && s_axil_rready));
    rd = s_axil_rdata;
    rs = s_axil_rresp;
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(nm, exp, rd);
  endtask
  task wait_dis(input logic v);
    for (n = 0; n < 5000 && discharge_en !== v; n++) @(posedge clk_sys);
  endtask
  task adc(input logic [3:0] c, input logic [15:0] d);
    adc_channel <= c;
    adc_data <= d;
    repeat (3) @(posedge clk_sys);
    chk("no sample no alarm", 0, alert_oe);
    adc_valid <= 1'b1;
    @(posedge clk_sys);
    adc_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task meas(input int hold, input logic [16:0] ev);
    wait_dis(1'b1);
    t0 = cyc;
    repeat (hold) @(posedge clk_sys);
    step_reached <= 1'b1;
    wait_dis(1'b0);
    step_reached <= 1'b0;
    for (n = 0; n < 500 && !esr_switch; n++) @(posedge clk_sys);
    chk("esr switching", 1, esr_switch);
    for (n = 0; n < 500 && !charger_disable; n++) @(posedge clk_sys);
    esr_value <= ev;
    esr_valid <= 1'b1;
    @(posedge clk_sys);
    esr_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rc("ctl reset", `SCM_A_CTL, 32'h0);
    rc("alarm reset", `SCM_A_ALARM, 32'h0);
    for (i = 0; i < 4; i++) begin
      {cell_count_sel_hi, cell_count_sel_lo} <= i[1:0];
      repeat (6) @(posedge clk_sys);
      rc("cell count", `SCM_A_COUNT, i);
    end
    wr(`SCM_A_COUNT, 16'h0000);
    rc("count read only", `SCM_A_COUNT, 32'h3);
    rd_reg(8'h30);
    chk("unmapped read", 2'b10, rs);
    s_axil_wstrb <= 4'h2;
    wr(`SCM_LVL_BASE, 16'h1234);
    s_axil_wstrb <= 4'hf;
    rc("byte lane", `SCM_LVL_BASE, 32'h1200);
    wr(`SCM_A_CTL, 16'h0004);
    chk("aux buffer", 1, aux_buffer_en);
    adc(4'd5, 16'h0200);
    chk("disabled limit", 0, alert_oe);
    for (i = 0; i < `SCM_NUM_ALARMS; i++) begin
      ch = (i < 2) ? 4'(3 * i) : (i < 10) ? 4'(i / 2 + 3) : (i < 12) ? 4'(i - 2) : 4'd10;
      ara_delay <= i[0] ? 8'h00 : 8'h14;
      wr(`SCM_LVL_BASE + 8'(4 * i), 16'h0100);
      wr(`SCM_A_ALM_MSK, 16'(1 << i));
      adc(ch, 16'h0100);
      chk("at level", 0, alert_oe);
      adc(ch, od[i] ? 16'h0180 : 16'h0080);
      chk("alert set", 1, alert_oe);
      repeat (30) @(posedge clk_sys);
      chk("alert released", 0, alert_oe);
      rc("alarm latched", `SCM_A_ALARM, 32'(1 << i));
      if (i[0]) wr(`SCM_A_ALM_CLR, 16'(1 << i));
      else wr(`SCM_A_ALM_MSK, 16'h0000);
      rc("alarm cleared", `SCM_A_ALARM, 32'h0);
    end
    answer_en <= 1'b0;
    wr(`SCM_A_MON_MSK, 16'h0004);
    wr(`SCM_A_CTL, 16'h0007);
    wait_dis(1'b1);
    rc("start clears", `SCM_A_CTL, 32'h6);
    meas(4000, 17'd500);
    chk("monitor alert", 1, alert_oe);
    rd_reg(`SCM_A_MON);
    chk("pass flags", 32'hc, rd & 32'hf);
    rc("esr result", `SCM_A_ESR, 32'd500);
    rd_reg(`SCM_A_CAP);
    c1 = rd;
    answer_en <= 1'b1;
    wr(`SCM_A_MON_MSK, 16'h0000);
    repeat (30) @(posedge clk_sys);
    chk("monitor alert released", 0, alert_oe);
    wr(`SCM_A_CTL, 16'h0005);
    meas(4000, 17'd65537);
    charge_complete <= 1'b0;
    rd_reg(`SCM_A_MON);
    chk("esr over limit", 32'h2, rd & 32'h3);
    rd_reg(`SCM_A_CAP);
    c0 = rd;
    chk("scale ratio", 1, c0 > 0 && c1 >= 90 * c0 && c1 <= 110 * c0);
    wr(`SCM_A_CTL, 16'h0001);
    repeat (20) @(posedge clk_sys);
    chk("charge wait", 0, discharge_en);
    charge_complete <= 1'b1;
    wait_dis(1'b1);
    charge_good_output <= 1'b0;
    wait_dis(1'b0);
    charge_good_output <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd_reg(`SCM_A_MON);
    chk("cap trip flags", 32'h3, rd & 32'h3);
    wr(`SCM_A_CTL, 16'h0001);
    wait_dis(1'b1);
    power_fail <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("backup entered", 1, backup_mode);
    chk("test aborted", 0, discharge_en);
    power_fail <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd_reg(`SCM_A_MON);
    chk("power fail flags", 32'h3, rd & 32'h3);
    wr(`SCM_A_PERIOD, 16'h0003);
    wr(`SCM_A_CTL, 16'h0001);
    meas(10, 17'h08000);
    chk("esr current", 2'd1, esr_current_sel);
    wait_dis(1'b1);
    chk("rerun spacing", 1, (cyc - t0) inside {[298:303]});
    wr(`SCM_A_PERIOD, 16'h0000);
    meas(10, 17'd100);
    c0 = 0;
    repeat (1000) begin
      @(posedge clk_sys);
      c0 += discharge_en;
    end
    chk("no rerun", 0, c0);
    close_out();
  end
endmodule
`default_nettype wire
